// file: pkg/bcpc_pkg.sv
// shared constants, register map and carrier types of the motor commutation block
package bcpc_pkg;
  // timebase figures
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned PWM_FREQ_HZ = 12_475;
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int unsigned TACHO_WIDTH_US = 10;
  localparam int unsigned TACHO_WIDTH_CYC = TACHO_WIDTH_US * (CLK_HZ / 1_000_000);

  // sawtooth code range, 12-bit levels
  localparam int unsigned SAW_W = 12;
  localparam logic [11:0] SAW_LOW_RST = 12'h0155;
  localparam logic [11:0] SAW_HIGH_RST = 12'h0d55;
  localparam logic [11:0] SPEED_RST = 12'h0000;
  localparam int unsigned SAW_SPAN_RST = 32'(SAW_HIGH_RST) - 32'(SAW_LOW_RST);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SPEED = 8'h04;
  localparam logic [7:0] OFS_SAW_LOW = 8'h08;
  localparam logic [7:0] OFS_SAW_HIGH = 8'h0c;
  localparam logic [7:0] OFS_TACHO_W = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned ST_DIR_BIT = 3;
  localparam int unsigned ST_OC_BIT = 4;
  localparam int unsigned ST_UV_BIT = 5;
  localparam int unsigned ST_TACHO_BIT = 6;
  localparam int unsigned ST_PWM_BIT = 7;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_OC_BIT = 0;
  localparam int unsigned IRQ_UV_BIT = 1;
  localparam int unsigned IRQ_TACHO_BIT = 2;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // synchronised pin group; hall is {u,v,w}
  typedef struct packed {
    logic [2:0] hall;
    logic dir;
    logic oc;
    logic uvlo;
  } bcpc_pins_t;

  // gate drive group; index 2 is phase u, 0 is phase w
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } bcpc_gates_t;

  typedef enum logic [1:0] {
    OC_RUN = 2'b01,
    OC_BLANK = 2'b10
  } bcpc_oc_state_t;
endpackage : bcpc_pkg

// file: design/bcpc_top.sv
// three-phase commutation, pwm chopping, over-current blanking, tacho one-shot and apb registers
// Operation
// [R1] direction high: six hall codes select arm pairs
// [R2] direction low: reversed six-code arm pair table
// [R3] hall all-low or all-high: every gate off
// [R4] pwm from speed command against sawtooth
// [R5] below low level 0%, above high 100%
// [R6] chop only the active low-side arm
// [R7] over-current turns off all low-side gates
// [R8] retry low-side enable once per period
// [R9] oscillator visible on monitor output
// [R10] tacho one-shot on synthesized hall rise
// [R11] retrigger keeps tacho output high gaplessly
// [R12] three tacho pulses per electrical revolution
// [R13] undervoltage: all gates and charge pump off
// [R14] host changes direction only at low speed
// [R15] blanking flag clears per period unless still over
// [R16] never both arms of one phase
`timescale 1ns/1ps
module bcpc_top #(
  parameter int unsigned PWM_PERIOD_CYC = bcpc_pkg::PWM_PERIOD_CYC,
  parameter int unsigned TACHO_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [2:0] i_hall,
  input wire logic i_direction_select,
  input wire logic i_current_sense_input,
  input wire logic i_supply_undervoltage_lockout,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [2:0] o_high_side_gate,
  output logic [2:0] o_low_side_gate,
  output logic o_tacho_pulse_out,
  output logic o_oscillator_monitor,
  output logic o_charge_pump_enable,
  output logic o_irq
);
  localparam int unsigned STEP_CYC = PWM_PERIOD_CYC / bcpc_pkg::SAW_SPAN_RST;

  initial
  begin
    if (STEP_CYC < 1 || STEP_CYC > 65535 || TACHO_W < 12 || TACHO_W > 32)
      $error("bcpc_top: unsupported parameter values");
  end

  bcpc_pkg::bcpc_pins_t pins_meta_r, pins_s_r;
  logic ctrl_en_r, ctrl_en_nxt;
  logic [11:0] speed_r, speed_nxt, saw_low_r, saw_low_nxt, saw_high_r, saw_high_nxt;
  logic [TACHO_W-1:0] tacho_w_r, tacho_w_nxt, tacho_cnt_r, tacho_cnt_nxt;
  logic [2:0] irq_mask_r, irq_mask_nxt, irq_stat_r, irq_stat_nxt, irq_evt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, wr_en;
  logic [15:0] step_r, step_nxt;
  logic [11:0] saw_r, saw_nxt;
  logic [12:0] saw_mid;
  logic period_start, osc_r, osc_nxt, pwm_r, pwm_nxt;
  bcpc_pkg::bcpc_oc_state_t oc_st_r, oc_st_nxt;
  logic synth_r, synth_nxt, hall_rise, uv_prev_r;
  logic tacho_r, tacho_nxt, cp_en_r, cp_en_nxt, irq_r, irq_nxt;
  bcpc_pkg::bcpc_gates_t gates_r, gates_nxt, comm;

  // two-stage synchroniser for every pin input; the first stage feeds only the second
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      pins_meta_r <= '0;
      pins_s_r <= '0;
    end
    else
    begin
      pins_meta_r <= {i_hall, i_direction_select, i_current_sense_input, i_supply_undervoltage_lockout};
      pins_s_r <= pins_meta_r;
    end
  end

  // apb decode; zero-wait answer prepared in the setup cycle, unmapped offsets raise pslverr
  always_comb
  begin
    wr_en = i_psel & i_penable & pready_r & i_pwrite;
    pready_nxt = i_psel & ~i_penable;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    ctrl_en_nxt = ctrl_en_r;
    speed_nxt = speed_r;
    saw_low_nxt = saw_low_r;
    saw_high_nxt = saw_high_r;
    tacho_w_nxt = tacho_w_r;
    irq_mask_nxt = irq_mask_r;
    case (i_paddr)
      bcpc_pkg::OFS_CTRL: prdata_nxt[bcpc_pkg::CTRL_EN_BIT] = ctrl_en_r;
      bcpc_pkg::OFS_SPEED: prdata_nxt[11:0] = speed_r;
      bcpc_pkg::OFS_SAW_LOW: prdata_nxt[11:0] = saw_low_r;
      bcpc_pkg::OFS_SAW_HIGH: prdata_nxt[11:0] = saw_high_r;
      bcpc_pkg::OFS_TACHO_W: prdata_nxt[TACHO_W-1:0] = tacho_w_r;
      bcpc_pkg::OFS_STATUS: prdata_nxt[7:0] = {pwm_r, tacho_r, pins_s_r.uvlo, oc_st_r == bcpc_pkg::OC_BLANK,
                                               pins_s_r.dir, pins_s_r.hall};
      bcpc_pkg::OFS_IRQ_STAT: prdata_nxt[2:0] = irq_stat_r;
      bcpc_pkg::OFS_IRQ_MASK: prdata_nxt[2:0] = irq_mask_r;
      default: pslverr_nxt = pready_nxt;
    endcase
    if (wr_en)
    begin
      case (i_paddr)
        bcpc_pkg::OFS_CTRL: ctrl_en_nxt = i_pwdata[bcpc_pkg::CTRL_EN_BIT];
        bcpc_pkg::OFS_SPEED: speed_nxt = i_pwdata[11:0];
        bcpc_pkg::OFS_SAW_LOW: saw_low_nxt = i_pwdata[11:0];
        bcpc_pkg::OFS_SAW_HIGH: saw_high_nxt = i_pwdata[11:0];
        bcpc_pkg::OFS_TACHO_W: tacho_w_nxt = i_pwdata[TACHO_W-1:0];
        bcpc_pkg::OFS_IRQ_MASK: irq_mask_nxt = i_pwdata[2:0];
        default: ctrl_en_nxt = ctrl_en_r;
      endcase
    end
  end

  // register file and bus answer flops
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      ctrl_en_r <= bcpc_pkg::CTRL_EN_RST;
      speed_r <= bcpc_pkg::SPEED_RST;
      saw_low_r <= bcpc_pkg::SAW_LOW_RST;
      saw_high_r <= bcpc_pkg::SAW_HIGH_RST;
      tacho_w_r <= TACHO_W'(bcpc_pkg::TACHO_WIDTH_CYC);
      irq_mask_r <= bcpc_pkg::IRQ_MASK_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ctrl_en_r <= ctrl_en_nxt;
      speed_r <= speed_nxt;
      saw_low_r <= saw_low_nxt;
      saw_high_r <= saw_high_nxt;
      tacho_w_r <= tacho_w_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // sawtooth timebase: period follows the programmed span plus one level, times the fixed step
  always_comb
  begin
    period_start = 1'b0;
    step_nxt = step_r + 16'h0001;
    saw_nxt = saw_r;
    saw_mid = ({1'b0, saw_low_r} + {1'b0, saw_high_r}) >> 1;
    if (step_r >= 16'(STEP_CYC - 1))
    begin
      step_nxt = 16'h0000;
      if (saw_r >= saw_high_r)
      begin
        saw_nxt = saw_low_r;
        period_start = 1'b1;
      end
      else
        saw_nxt = saw_r + 12'h001;
    end
    osc_nxt = {1'b0, saw_r} < saw_mid; // see [R9]
    if (speed_r > saw_high_r)
      pwm_nxt = 1'b1; // see [R5]
    else if (speed_r < saw_low_r)
      pwm_nxt = 1'b0; // see [R5]
    else
      pwm_nxt = speed_r > saw_r; // see [R4]
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      step_r <= 16'h0000;
      saw_r <= bcpc_pkg::SAW_LOW_RST;
      osc_r <= 1'b0;
      pwm_r <= 1'b0;
    end
    else
    begin
      step_r <= step_nxt;
      saw_r <= saw_nxt;
      osc_r <= osc_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  // over-current blanking; a still-high comparator keeps the flag across the period start
  always_comb
  begin
    case (oc_st_r)
      bcpc_pkg::OC_RUN: oc_st_nxt = pins_s_r.oc ? bcpc_pkg::OC_BLANK : bcpc_pkg::OC_RUN; // see [R7]
      bcpc_pkg::OC_BLANK: oc_st_nxt = (period_start && !pins_s_r.oc) ? bcpc_pkg::OC_RUN
                                                                        : bcpc_pkg::OC_BLANK; // see [R8] [R15]
      default: oc_st_nxt = bcpc_pkg::OC_BLANK;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      oc_st_r <= bcpc_pkg::OC_RUN;
    else
      oc_st_r <= oc_st_nxt;
  end

  // tacho: parity of the hall code flips at every commutation step, so it rises three times per turn
  always_comb
  begin
    synth_nxt = ^pins_s_r.hall; // see [R12]
    hall_rise = synth_nxt & ~synth_r;
    tacho_cnt_nxt = tacho_cnt_r;
    if (hall_rise)
      tacho_cnt_nxt = tacho_w_r; // see [R10] [R11]
    else if (tacho_cnt_r != '0)
      tacho_cnt_nxt = tacho_cnt_r - TACHO_W'(1);
    tacho_nxt = tacho_cnt_nxt != '0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      synth_r <= 1'b0;
      tacho_cnt_r <= '0;
      tacho_r <= 1'b0;
    end
    else
    begin
      synth_r <= synth_nxt;
      tacho_cnt_r <= tacho_cnt_nxt;
      tacho_r <= tacho_nxt;
    end
  end

  // commutation table; each entry picks one high arm and one low arm of different phases
  function automatic bcpc_pkg::bcpc_gates_t bcpc_commutate(input logic dir, input logic [2:0] h);
    bcpc_pkg::bcpc_gates_t g;
    g = '0;
    case ({dir, h})
      4'b1101: g = '{hs: 3'b010, ls: 3'b100}; // see [R1]
      4'b1100: g = '{hs: 3'b001, ls: 3'b100};
      4'b1110: g = '{hs: 3'b001, ls: 3'b010};
      4'b1010: g = '{hs: 3'b100, ls: 3'b010};
      4'b1011: g = '{hs: 3'b100, ls: 3'b001};
      4'b1001: g = '{hs: 3'b010, ls: 3'b001};
      4'b0110: g = '{hs: 3'b010, ls: 3'b001}; // see [R2]
      4'b0100: g = '{hs: 3'b100, ls: 3'b001};
      4'b0101: g = '{hs: 3'b100, ls: 3'b010};
      4'b0001: g = '{hs: 3'b001, ls: 3'b010};
      4'b0011: g = '{hs: 3'b001, ls: 3'b100};
      4'b0010: g = '{hs: 3'b010, ls: 3'b100};
      default: g = '0; // see [R3]
    endcase
    return g;
  endfunction : bcpc_commutate

  // gate drive, charge pump, interrupts; direction is taken live, so reversal at speed is the host's care
  always_comb
  begin
    comm = bcpc_commutate(pins_s_r.dir, pins_s_r.hall);
    gates_nxt = comm;
    gates_nxt.ls = comm.ls & {3{pwm_r}}; // see [R6]
    if (oc_st_nxt == bcpc_pkg::OC_BLANK)
      gates_nxt.ls = 3'h0; // see [R7]
    if (!ctrl_en_r || pins_s_r.uvlo)
      gates_nxt = '0; // see [R13]
    gates_nxt.ls = gates_nxt.ls & ~gates_nxt.hs; // see [R16]
    cp_en_nxt = ~pins_s_r.uvlo; // see [R13]
    irq_evt = '0;
    irq_evt[bcpc_pkg::IRQ_OC_BIT] = (oc_st_r == bcpc_pkg::OC_RUN) && (oc_st_nxt == bcpc_pkg::OC_BLANK);
    irq_evt[bcpc_pkg::IRQ_UV_BIT] = pins_s_r.uvlo & ~uv_prev_r;
    irq_evt[bcpc_pkg::IRQ_TACHO_BIT] = hall_rise;
    // set beats a write-one clear landing in the same cycle
    irq_stat_nxt = irq_stat_r;
    if (wr_en && i_paddr == bcpc_pkg::OFS_IRQ_STAT)
      irq_stat_nxt = irq_stat_r & ~i_pwdata[2:0];
    irq_stat_nxt = irq_stat_nxt | irq_evt;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      gates_r <= '0;
      cp_en_r <= 1'b0;
      uv_prev_r <= 1'b0;
      irq_stat_r <= 3'h0;
      irq_r <= 1'b0;
    end
    else
    begin
      gates_r <= gates_nxt;
      cp_en_r <= cp_en_nxt;
      uv_prev_r <= pins_s_r.uvlo;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_high_side_gate = gates_r.hs;
  assign o_low_side_gate = gates_r.ls;
  assign o_tacho_pulse_out = tacho_r;
  assign o_oscillator_monitor = osc_r;
  assign o_charge_pump_enable = cp_en_r;
  assign o_irq = irq_r;

  // checks on the driven outputs, the pwm flop and the blanking state
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  logic run_ok;
  assign run_ok = ctrl_en_r && !pins_s_r.uvlo;

  sequence s_blank_at_wrap;
    (oc_st_r == bcpc_pkg::OC_BLANK) && period_start;
  endsequence

  a_dir_high_table: assert property (run_ok && pins_s_r.dir && pins_s_r.hall == 3'b101 // see [R1]
    |=> o_high_side_gate == 3'b010 && (o_low_side_gate & 3'b011) == 3'b000)
    else $error("forward table entry wrong");
  a_dir_low_table: assert property (run_ok && !pins_s_r.dir && pins_s_r.hall == 3'b100 // see [R2]
    |=> o_high_side_gate == 3'b100 && (o_low_side_gate & 3'b110) == 3'b000)
    else $error("reverse table entry wrong");
  a_bad_hall_off: assert property ((pins_s_r.hall == 3'b000 || pins_s_r.hall == 3'b111) // see [R3]
    |=> o_high_side_gate == 3'b000 && o_low_side_gate == 3'b000)
    else $error("gates on with invalid hall code");
  a_pwm_extremes: assert property ((speed_r < saw_low_r |=> !pwm_r) and (speed_r > saw_high_r |=> pwm_r)) // see [R5]
    else $error("pwm not forced at command extremes");
  a_hs_not_chopped: assert property (run_ok && !pwm_r && oc_st_nxt == bcpc_pkg::OC_RUN && comm.hs != 3'h0 // see [R6]
    |=> o_high_side_gate != 3'h0 && o_low_side_gate == 3'h0)
    else $error("high arm chopped or low arm on while pwm off");
  a_oc_low_off: assert property (pins_s_r.oc |=> o_low_side_gate == 3'h0) // see [R7]
    else $error("low arm on during over-current");
  a_oc_retry_wrap: assert property (s_blank_at_wrap ##0 !pins_s_r.oc |=> oc_st_r == bcpc_pkg::OC_RUN) // see [R8]
    else $error("blanking not released at period start");
  a_oc_hold_flag: assert property ((oc_st_r == bcpc_pkg::OC_BLANK) && (!period_start || pins_s_r.oc) // see [R15]
    |=> oc_st_r == bcpc_pkg::OC_BLANK)
    else $error("blanking released too early");
  a_osc_monitor: assert property (period_start |=> ##1 o_oscillator_monitor) // see [R9]
    else $error("oscillator monitor low after period start");
  a_tacho_start: assert property (hall_rise && tacho_w_r > TACHO_W'(2) |=> o_tacho_pulse_out [*2]) // see [R10]
    else $error("tacho pulse not started");
  a_tacho_retrig: assert property (o_tacho_pulse_out && hall_rise && tacho_w_r != '0 // see [R11]
    |=> o_tacho_pulse_out)
    else $error("tacho gap on retrigger");
  a_uvlo_all_off: assert property (pins_s_r.uvlo // see [R13]
    |=> o_high_side_gate == 3'h0 && o_low_side_gate == 3'h0 && !o_charge_pump_enable)
    else $error("drive active during undervoltage");
  a_no_shoot: assert property ((o_high_side_gate & o_low_side_gate) == 3'h0) // see [R16]
    else $error("both arms of one phase on");
endmodule : bcpc_top

// file: bench/bcpc_motor_model.sv
// motor side model: hall sensor rotation and bridge current sense
`timescale 1ns/1ps
module bcpc_motor_model (
  input wire logic i_clk_sys,
  input wire logic i_step,
  input wire logic i_load,
  input wire logic [2:0] i_code,
  input wire logic i_oc_req,
  input wire bcpc_pkg::bcpc_gates_t i_gates,
  output logic [2:0] o_hall,
  output logic o_current_sense,
  output int o_shoot_cnt
);
  // forward hall sequence, six codes per electrical turn
  logic [2:0] seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  int idx = 0;
  initial o_hall = 3'h0;
  initial o_shoot_cnt = 0;
  // sensors move only when commanded; a load drives the given code and resets the turn index to its first entry
  always @(posedge i_clk_sys)
  begin
    if (i_load)
    begin
      o_hall <= i_code;
      idx <= 0;
    end
    else if (i_step)
    begin
      o_hall <= seq[(idx + 1) % 6];
      idx <= (idx + 1) % 6;
    end
  end
  // a leg with both arms on is a short, so it shows as over-current like a real bridge
  always @(posedge i_clk_sys)
    if ((i_gates.hs & i_gates.ls) != 3'h0)
      o_shoot_cnt <= o_shoot_cnt + 1;
  assign o_current_sense = i_oc_req | ((i_gates.hs & i_gates.ls) != 3'h0);
endmodule : bcpc_motor_model

// file: bench/bcpc_top_test.sv
// self-checking bench for the motor commutation block
`timescale 1ns/1ps
module bcpc_top_test;
  localparam int unsigned PER = 3072;
  // one saw step per cycle, so a period is one cycle per saw level
  localparam int SAW_CYC = (bcpc_pkg::SAW_SPAN_RST + 1) * (PER / 3072);
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_direction_select = 1'b1;
  logic i_supply_undervoltage_lockout = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic step = 1'b0;
  logic load = 1'b0;
  logic [2:0] code = 3'h0;
  logic oc_req = 1'b0;
  logic [2:0] hall;
  logic sense;
  int shoot;
  logic [31:0] prdata;
  logic pready, pslverr, tacho, mon, cp, irq;
  logic [2:0] hs;
  logic [2:0] ls;
  int n_errors = 0;
  int comparisons = 0;

  bcpc_top #(.PWM_PERIOD_CYC(PER), .TACHO_W(16)) dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_hall(hall), .i_direction_select(i_direction_select),
    .i_current_sense_input(sense), .i_supply_undervoltage_lockout(i_supply_undervoltage_lockout),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_high_side_gate(hs), .o_low_side_gate(ls),
    .o_tacho_pulse_out(tacho), .o_oscillator_monitor(mon), .o_charge_pump_enable(cp), .o_irq(irq));

  bcpc_motor_model motor (.i_clk_sys(i_clk_sys), .i_step(step), .i_load(load), .i_code(code), .i_oc_req(oc_req),
    .i_gates({hs, ls}), .o_hall(hall), .o_current_sense(sense), .o_shoot_cnt(shoot));

  // 200 MHz system clock
  always #2.5 i_clk_sys = ~i_clk_sys;

  task finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is seen high at a rising edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    // the answer flops update by non-blocking assignment, so values read here are those the edge sampled
    @(posedge i_clk_sys);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n == 16)
      n_errors++;
    rd = prdata;
    err = pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(a, 1'b1, d, rd, err);
    check(32'(err), 32'h0);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic err;
    apb(a, 1'b0, 32'h0, rd, err);
    check(rd & m, exp);
    check(32'(err), 32'(eerr));
  endtask : rchk

  // wait n edges, then look once the edge's updates have landed
  task cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  task set_hall(input logic [2:0] c);
    @(posedge i_clk_sys);
    load <= 1'b1;
    code <= c;
    @(posedge i_clk_sys);
    load <= 1'b0;
  endtask : set_hall

  // rotate the motor and count tacho pulses and high cycles
  task spin(input int steps, input int gap, input int tail, output int rises, output int highs);
    logic prev;
    rises = 0;
    highs = 0;
    prev = tacho;
    for (int s = 0; s < steps * gap + tail; s++)
    begin
      @(posedge i_clk_sys);
      step <= (s % gap == 0) && (s < steps * gap);
      #1;
      rises += (tacho && !prev);
      highs += tacho;
      prev = tacho;
    end
  endtask : spin

  // watch n cycles at hall 101, direction low: high arm u fixed, low arm v chopped
  task watch(input int n, output int lows, output int rises, output int badh);
    logic prev;
    lows = 0;
    rises = 0;
    badh = 0;
    prev = mon;
    repeat (n)
    begin
      @(posedge i_clk_sys);
      #1;
      lows += (ls != 3'h0);
      rises += (mon && !prev);
      badh += (hs !== 3'h4) || (ls !== 3'h0 && ls !== 3'h2);
      prev = mon;
    end
  endtask : watch

  function automatic bcpc_pkg::bcpc_gates_t gexp(input logic d, input logic [2:0] c);
    bcpc_pkg::bcpc_gates_t g;
    case (c)
      3'h5: g = '{hs: 3'h2, ls: 3'h4};
      3'h4: g = '{hs: 3'h1, ls: 3'h4};
      3'h6: g = '{hs: 3'h1, ls: 3'h2};
      3'h2: g = '{hs: 3'h4, ls: 3'h2};
      3'h3: g = '{hs: 3'h4, ls: 3'h1};
      3'h1: g = '{hs: 3'h2, ls: 3'h1};
      default: g = '{hs: 3'h0, ls: 3'h0};
    endcase
    // reverse rotation swaps the high and low arm of each step
    if (!d)
      g = '{hs: g.ls, ls: g.hs};
    return g;
  endfunction : gexp

  task test_regs();
    rchk(bcpc_pkg::OFS_CTRL, 32'hffff_ffff, 32'(bcpc_pkg::CTRL_EN_RST), 1'b0);
    rchk(bcpc_pkg::OFS_SPEED, 32'hffff_ffff, 32'(bcpc_pkg::SPEED_RST), 1'b0);
    rchk(bcpc_pkg::OFS_SAW_LOW, 32'hffff_ffff, 32'(bcpc_pkg::SAW_LOW_RST), 1'b0);
    rchk(bcpc_pkg::OFS_SAW_HIGH, 32'hffff_ffff, 32'(bcpc_pkg::SAW_HIGH_RST), 1'b0);
    rchk(bcpc_pkg::OFS_TACHO_W, 32'hffff_ffff, bcpc_pkg::TACHO_WIDTH_CYC, 1'b0);
    rchk(bcpc_pkg::OFS_IRQ_MASK, 32'hffff_ffff, 32'(bcpc_pkg::IRQ_MASK_RST), 1'b0);
    rchk(8'h20, 32'hffff_ffff, 32'h0, 1'b1);
  endtask : test_regs

  task test_tacho();
    int rises;
    int highs;
    wr(bcpc_pkg::OFS_TACHO_W, 32'h0000_0014);
    set_hall(3'h5);
    cyc(8);
    check(32'({hs, ls}), 32'h0);
    spin(6, 40, 60, rises, highs);
    check(32'(rises), 32'h3);
    check(32'(highs), 32'h0000_003c);
    rchk(bcpc_pkg::OFS_IRQ_STAT, 32'h4, 32'h4, 1'b0);
    wr(bcpc_pkg::OFS_TACHO_W, 32'h0000_001e);
    spin(6, 10, 60, rises, highs);
    check(32'(rises), 32'h1);
    check(32'(highs), 32'h0000_0046);
  endtask : test_tacho

  task test_table();
    wr(bcpc_pkg::OFS_CTRL, 32'h0000_0001);
    for (int d = 1; d >= 0; d--)
    begin
      // direction flips only with the speed command at zero
      wr(bcpc_pkg::OFS_SPEED, 32'h0000_0000);
      @(posedge i_clk_sys);
      i_direction_select <= d[0];
      wr(bcpc_pkg::OFS_SPEED, 32'h0000_0fff);
      for (int c = 0; c < 8; c++)
      begin
        set_hall(c[2:0]);
        cyc(4);
        check(32'({hs, ls}), 32'(gexp(d[0], c[2:0])));
      end
    end
  endtask : test_table

  task test_pwm();
    logic [11:0] spd [5] = '{12'h100, 12'h155, 12'h755, 12'hd55, 12'he00};
    int exp [5] = '{0, 0, 1536, 3072, 3073};
    int lows;
    int rises;
    int badh;
    set_hall(3'h5);
    for (int i = 0; i < 5; i++)
    begin
      wr(bcpc_pkg::OFS_SPEED, 32'(spd[i]));
      cyc(4);
      watch(SAW_CYC, lows, rises, badh);
      check(32'(lows), 32'(exp[i]));
      check(32'(rises), 32'h1);
      check(32'(badh), 32'h0);
    end
  endtask : test_pwm

  task test_oc();
    int lows;
    int rises;
    int badh;
    int n;
    wr(bcpc_pkg::OFS_SPEED, 32'h0000_0fff);
    @(posedge i_clk_sys);
    oc_req <= 1'b1;
    cyc(4);
    check(32'({hs, ls}), 32'h0000_0020);
    watch(SAW_CYC + 8, lows, rises, badh);
    check(32'(lows), 32'h0);
    rchk(bcpc_pkg::OFS_IRQ_STAT, 32'h1, 32'h1, 1'b0);
    check(32'(irq), 32'h0);
    wr(bcpc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    cyc(2);
    check(32'(irq), 32'h1);
    @(posedge i_clk_sys);
    oc_req <= 1'b0;
    n = 0;
    while (ls !== 3'h2 && n < 2 * SAW_CYC)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    check(32'(n <= SAW_CYC + 8), 32'h1);
    wr(bcpc_pkg::OFS_IRQ_STAT, 32'h0000_0007);
    cyc(2);
    check(32'(irq), 32'h0);
    wr(bcpc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
  endtask : test_oc

  task test_uvlo();
    check(32'(cp), 32'h1);
    @(posedge i_clk_sys);
    i_supply_undervoltage_lockout <= 1'b1;
    cyc(4);
    check(32'({cp, hs, ls}), 32'h0);
    rchk(bcpc_pkg::OFS_IRQ_STAT, 32'h2, 32'h2, 1'b0);
    // status: uvlo set, not blanked, direction low, hall 101
    rchk(bcpc_pkg::OFS_STATUS, 32'h0000_003f, 32'h0000_0025, 1'b0);
    @(posedge i_clk_sys);
    i_supply_undervoltage_lockout <= 1'b0;
    cyc(4);
    check(32'({cp, hs, ls}), 32'h0000_0062);
  endtask : test_uvlo

  // main sequence
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    test_regs();
    test_tacho();
    test_table();
    test_pwm();
    test_oc();
    test_uvlo();
    check(32'(shoot), 32'h0);
    finish_test();
  end

  // watchdog: the run needs about 21.5k cycles
  initial
  begin
    repeat (60000) @(posedge i_clk_sys);
    n_errors++;
    finish_test();
  end
endmodule : bcpc_top_test
